// >>> pbc_brake_prescale.sv
// pwm brake, prescaler, counter core and axi4-lite register slave
//
// Summary of operation
// [RULE_01] both selects zero: brake held continuously
// [RULE_02] idle select: brake only while counter stopped
// [RULE_03] pin brake: stop counter, set flag
// [RULE_04] both selects one is disallowed, no brake
// [RULE_05] selects evaluated only with brake enabled
// [RULE_06] pin active when level equals polarity bit
// [RULE_07] brake forces outputs to brake levels
// [RULE_08] after brake, outputs resume pre-brake state
// [RULE_09] flag sticky until software clears it
// [RULE_10] flag raises the pwm interrupt request
// [RULE_11] prescale divides by one, two, four, sixteen
// [RULE_12] prescaled clock phase aligned while running
// [RULE_13] duty is compare over period plus one
// [RULE_14] polarity zero low active, one high active
// [RULE_15] brake disabled means never brake
// [RULE_16] run bit starts and stops counter
// [RULE_17] reserved bits read zero, ignore writes
//
// Added by the designer: the AXI4-Lite slave port.
module pbc_brake_prescale (
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  input  wire  pbc_pkg::pbc_axil_req_t s_axi_req,
  output pbc_pkg::pbc_axil_rsp_t       s_axi_rsp,
  input  wire  logic                   brake_pin,
  output logic [pbc_pkg::NUM_OUT-1:0]  pwm_out,
  output logic                         irq
);
  import pbc_pkg::*;

  typedef struct packed {
    logic [7:0]                    cfg;
    logic                          run;
    logic [NUM_OUT-1:0]            inv;
    logic [1:0]                    presel;
    logic                          flag;
    logic                          mask;
    logic [CNT_W-1:0]              period;
    logic [NUM_OUT-1:0][CNT_W-1:0] cmp;
    logic [CNT_W-1:0]              cnt;
    logic [3:0]                    pre;
    logic [NUM_OUT-1:0]            held;
    logic [NUM_OUT-1:0]            out;
    logic                          pin1;
    logic                          pin2;
    logic                          aw_got;
    logic [ADDR_W-1:0]             awaddr;
    logic                          w_got;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } pbc_state_t;

  pbc_state_t s_reg;
  pbc_state_t s_next;

  function automatic pbc_sel_t pbc_decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    if (idx == IDX_RUN_CONTROL) return PBC_SEL_RUN;
    if (idx == IDX_BRAKE_CONFIG) return PBC_SEL_CFG;
    if (idx == IDX_BRAKE_PRESCALE) return PBC_SEL_BP;
    if (idx == IDX_IRQ_MASK) return PBC_SEL_MASK;
    if (idx == IDX_PERIOD) return PBC_SEL_PER;
    if (idx >= IDX_COMPARE0 && idx < IDX_COMPARE0 + 10'(NUM_OUT)) return PBC_SEL_CMP;
    return PBC_SEL_NONE;
  endfunction

  function automatic logic [3:0] pbc_pre_mask(input logic [1:0] sel);
    case (sel)
      2'h0: return PRE_MASK_DIV1;
      2'h1: return PRE_MASK_DIV2;
      2'h2: return PRE_MASK_DIV4;
      default: return PRE_MASK_DIV16;
    endcase
  endfunction

  logic               en;
  logic               psel;
  logic               isel;
  logic               pin_act;
  logic               pin_brk;
  logic               brake;
  logic               tick;
  logic [3:0]         pmask;
  logic [NUM_OUT-1:0] raw;
  logic               aw_take;
  logic               w_take;
  logic               ar_take;
  logic               commit;
  logic               flag_clr;
  pbc_sel_t           wsel;
  pbc_sel_t           rsel;
  logic [1:0]         widx;
  logic [1:0]         ridx;

  assign en      = s_reg.cfg[CFG_EN_BIT];                                     // [RULE_05] [RULE_15]
  assign psel    = s_reg.cfg[CFG_PSEL_BIT];
  assign isel    = s_reg.cfg[CFG_ISEL_BIT];
  // the pin is read only after the second synchroniser stage
  assign pin_act = (s_reg.pin2 == s_reg.cfg[CFG_POL_BIT]);                    // [RULE_06] [RULE_14]
  assign pin_brk = en & psel & ~isel & pin_act;                               // [RULE_03] [RULE_04]
  assign brake   = (en & ~psel & (~isel | ~s_reg.run)) | pin_brk;             // [RULE_01] [RULE_02]
  assign pmask   = pbc_pre_mask(s_reg.presel);
  assign tick    = s_reg.run & ((s_reg.pre & pmask) == pmask);                // [RULE_11]

  assign aw_take  = s_axi_req.awvalid & ~s_reg.aw_got & ~s_reg.bvalid;
  assign w_take   = s_axi_req.wvalid & ~s_reg.w_got & ~s_reg.bvalid;
  assign ar_take  = s_axi_req.arvalid & ~s_reg.rvalid;
  assign commit   = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
  assign wsel     = pbc_decode(s_reg.awaddr);
  assign rsel     = pbc_decode(s_axi_req.araddr);
  assign widx     = 2'(s_reg.awaddr[ADDR_W-1:2] - IDX_COMPARE0);
  assign ridx     = 2'(s_axi_req.araddr[ADDR_W-1:2] - IDX_COMPARE0);
  assign flag_clr = commit & (wsel == PBC_SEL_BP) & s_reg.wstrb[0] & s_reg.wdata[BP_FLAG_BIT];

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_raw
    assign raw[g] = (s_reg.cnt < s_reg.cmp[g]) ^ s_reg.inv[g];                // [RULE_13]
  end

  always_comb begin
    s_next = s_reg;
    s_next.pin1 = brake_pin;
    s_next.pin2 = s_reg.pin1;

    // stopped counter keeps its phase reset so the first tick lines up with run
    if (!s_reg.run) begin
      s_next.pre = 4'h0;                                                      // [RULE_12]
    end else if (tick) begin
      s_next.pre = 4'h0;
    end else begin
      s_next.pre = s_reg.pre + 4'h1;
    end
    if (tick) begin
      s_next.cnt = (s_reg.cnt == '0) ? s_reg.period : s_reg.cnt - 1'b1;       // [RULE_13] [RULE_16]
    end

    // held freezes while braked, outputs take the brake levels and come back to the last unbraked value
    if (s_reg.run && !brake) begin
      s_next.held = raw;                                                      // [RULE_08]
    end
    s_next.out = brake ? s_reg.cfg[CFG_LEVEL_LSB +: NUM_OUT] : s_reg.held;    // [RULE_07] [RULE_08]

    if (aw_take) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_req.awaddr;
    end
    if (w_take) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_req.wdata;
      s_next.wstrb = s_axi_req.wstrb;
    end
    if (commit) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = (wsel == PBC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (wsel)
        PBC_SEL_RUN: if (s_reg.wstrb[0]) begin
          s_next.run = s_reg.wdata[RUN_BIT];
          s_next.inv = s_reg.wdata[RUN_INV_LSB +: NUM_OUT];
        end
        PBC_SEL_CFG: if (s_reg.wstrb[0]) begin
          s_next.cfg = s_reg.wdata[7:0];
        end
        PBC_SEL_BP: if (s_reg.wstrb[0]) begin
          s_next.presel = s_reg.wdata[BP_PRE_LSB +: 2];                       // [RULE_17]
        end
        PBC_SEL_MASK: if (s_reg.wstrb[0]) begin
          s_next.mask = s_reg.wdata[BP_FLAG_BIT];
        end
        PBC_SEL_PER: begin
          if (s_reg.wstrb[0]) s_next.period[7:0] = s_reg.wdata[7:0];
          if (s_reg.wstrb[1]) s_next.period[CNT_W-1:8] = s_reg.wdata[CNT_W-1:8];
        end
        PBC_SEL_CMP: begin
          if (s_reg.wstrb[0]) s_next.cmp[widx][7:0] = s_reg.wdata[7:0];
          if (s_reg.wstrb[1]) s_next.cmp[widx][CNT_W-1:8] = s_reg.wdata[CNT_W-1:8];
        end
        PBC_SEL_NONE: begin
        end
      endcase
    end else if (s_reg.bvalid && s_axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end

    // a pin brake beats a software run write in the same cycle
    if (pin_brk) begin
      s_next.run = 1'b0;                                                      // [RULE_03]
    end
    // set wins over the write-one clear
    s_next.flag = pin_brk | (s_reg.flag & ~flag_clr);                         // [RULE_03] [RULE_09]

    if (ar_take) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = (rsel == PBC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        PBC_SEL_RUN:  s_next.rdata = {24'h0, s_reg.run, 3'h0, s_reg.inv};
        PBC_SEL_CFG:  s_next.rdata = {24'h0, s_reg.cfg};
        PBC_SEL_BP:   s_next.rdata = {24'h0, 4'h0, s_reg.presel, 1'b0, s_reg.flag}; // [RULE_17]
        PBC_SEL_MASK: s_next.rdata = {31'h0, s_reg.mask};
        PBC_SEL_PER:  s_next.rdata = {22'h0, s_reg.period};
        PBC_SEL_CMP:  s_next.rdata = {22'h0, s_reg.cmp[ridx]};
        PBC_SEL_NONE: s_next.rdata = 32'h0;
      endcase
    end else if (s_reg.rvalid && s_axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_rsp.awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign s_axi_rsp.wready  = ~s_reg.w_got & ~s_reg.bvalid;
  assign s_axi_rsp.bvalid  = s_reg.bvalid;
  assign s_axi_rsp.bresp   = s_reg.bresp;
  assign s_axi_rsp.arready = ~s_reg.rvalid;
  assign s_axi_rsp.rvalid  = s_reg.rvalid;
  assign s_axi_rsp.rdata   = s_reg.rdata;
  assign s_axi_rsp.rresp   = s_reg.rresp;
  assign pwm_out = s_reg.out;
  // the brake flag is the only event, so irq is the flag gated by the mask bit
  assign irq     = s_reg.flag & s_reg.mask;                                   // [RULE_10]

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin_brake;
    en && psel && !isel && pin_act;
  endsequence

  sequence s_div16_gap;
    !tick [*8];
  endsequence

  sequence s_div4_gap;
    !tick ##1 !tick ##1 !tick;
  endsequence

  sequence s_tick_div16;
    tick && s_reg.presel == 2'h3 ##1 s_reg.run && s_reg.presel == 2'h3;
  endsequence

  sequence s_tick_div4;
    tick && s_reg.presel == 2'h2 ##1 s_reg.run && s_reg.presel == 2'h2;
  endsequence

  sequence s_tick_div2;
    tick && s_reg.presel == 2'h1 ##1 s_reg.run && s_reg.presel == 2'h1;
  endsequence

  sequence s_idle_brake;
    en && !psel && isel && !s_reg.run;
  endsequence

  sequence s_brake_end;
    brake ##1 !brake;
  endsequence

  sequence s_run_write;
    commit && wsel == PBC_SEL_RUN && s_reg.wstrb[0] && !pin_brk;
  endsequence

  sequence s_bp_read;
    ar_take && rsel == PBC_SEL_BP;
  endsequence

  sequence s_b_done;
    s_reg.bvalid && s_axi_req.bready;
  endsequence

  sequence s_r_done;
    s_reg.rvalid && s_axi_req.rready;
  endsequence

  sequence s_unmapped_write;
    commit && wsel == PBC_SEL_NONE;
  endsequence

  sequence s_unmapped_read;
    ar_take && rsel == PBC_SEL_NONE;
  endsequence

  chk_soft_brake: assert property (en && !psel && !isel |=> pwm_out == $past(s_reg.cfg[3:0])) // [RULE_01] [RULE_07]
    else $error("software brake did not force brake levels");
  chk_idle_release: assert property (en && !psel && isel && s_reg.run |=> pwm_out == $past(s_reg.held)) // [RULE_02]
    else $error("idle brake active while running");
  chk_pin_stop: assert property (s_pin_brake |=> !s_reg.run && s_reg.flag) // [RULE_03] [RULE_09]
    else $error("pin brake did not stop counter and set flag");
  chk_bad_combo: assert property (en && psel && isel |=> pwm_out == $past(s_reg.held)) // [RULE_04]
    else $error("disallowed select pair caused a brake");
  chk_no_brake: assert property (!en |=> pwm_out == $past(s_reg.held)) // [RULE_05] [RULE_15]
    else $error("brake asserted while disabled");
  chk_flag_sticky: assert property (s_reg.flag && !flag_clr |=> s_reg.flag) // [RULE_09]
    else $error("brake flag dropped without a clear");
  chk_irq_level: assert property (s_pin_brake ##1 s_reg.mask |-> irq) // [RULE_10]
    else $error("unmasked brake flag gave no interrupt");
  chk_div16_gap: assert property (s_tick_div16 |-> s_div16_gap) // [RULE_11]
    else $error("divide by sixteen ticked too early");
  // a stop may land on the expected tick, so only a running divider must tick
  chk_div2_tick: assert property (s_tick_div2 |=> !s_reg.run || tick) // [RULE_11]
    else $error("divide by two missed a tick");
  chk_div4_period: assert property (s_tick_div4 |-> s_div4_gap ##1 (!s_reg.run || tick)) // [RULE_11]
    else $error("divide by four period wrong");
  chk_div1_tick: assert property (s_reg.run && s_reg.presel == 2'h0 |-> tick) // [RULE_11]
    else $error("undivided clock missed a tick");
  chk_phase_align: assert property ($rose(s_reg.run) |-> s_reg.pre == 4'h0) // [RULE_12]
    else $error("prescaler not aligned at run start");
  chk_counter_hold: assert property (!s_reg.run |=> s_reg.cnt == $past(s_reg.cnt)) // [RULE_16]
    else $error("counter moved while stopped");
  chk_reload: assert property (tick && s_reg.cnt == '0 |=> s_reg.cnt == $past(s_reg.period)) // [RULE_13]
    else $error("counter did not reload the period");
  chk_hold_frozen: assert property (brake |=> s_reg.held == $past(s_reg.held)) // [RULE_08]
    else $error("pre-brake output state lost during brake");
  chk_reserved_zero: assert property (s_bp_read |=> s_reg.rdata[7:4] == 4'h0 && !s_reg.rdata[1]) // [RULE_17]
    else $error("reserved bits read nonzero");
  chk_pin_levels: assert property (s_pin_brake |=> pwm_out == $past(s_reg.cfg[3:0])) // [RULE_07]
    else $error("pin brake did not force brake levels");
  chk_idle_levels: assert property (s_idle_brake |=> pwm_out == $past(s_reg.cfg[3:0])) // [RULE_02] [RULE_07]
    else $error("idle brake did not force brake levels");
  chk_out_resume: assert property (s_brake_end |=> pwm_out == $past(s_reg.held, 2)) // [RULE_08]
    else $error("outputs did not resume pre-brake state");
  chk_held_update: assert property (s_reg.run && !brake |=> s_reg.held == $past(raw)) // [RULE_08]
    else $error("running outputs not tracked");
  chk_flag_clear: assert property (flag_clr && !pin_brk |=> !s_reg.flag) // [RULE_09]
    else $error("brake flag not cleared by write one");
  chk_run_write: assert property (s_run_write |=> s_reg.run == $past(s_reg.wdata[RUN_BIT])) // [RULE_16]
    else $error("run bit write lost");
  // bus answers stand until taken and drop right after
  chk_b_release: assert property (s_b_done |=> !s_reg.bvalid)
    else $error("write response not released");
  chk_r_release: assert property (s_r_done |=> !s_reg.rvalid)
    else $error("read response not released");
  chk_bresp_code: assert property (s_unmapped_write |=> s_reg.bvalid && s_reg.bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_rresp_code: assert property (s_unmapped_read |=> s_reg.rvalid && s_reg.rresp == RESP_SLVERR && s_reg.rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

// >>> pbc_brake_src.sv
// partner model: external brake pin driver and a load that counts high cycles of pwm output 0
module pbc_brake_src (
  input  wire logic                        aclk,
  input  wire logic                        pin_level,
  input  wire logic                        gate,
  input  wire logic [pbc_pkg::NUM_OUT-1:0] pwm_out,
  output logic                             brake_pin,
  output logic [15:0]                      hi_cnt
);
  import pbc_pkg::*;
  // pin follows the bench level one clock later, like a board driver
  always @(posedge aclk) begin
    brake_pin <= pin_level;
  end
  // counter clears while the gate is low, so each window starts from zero
  always @(posedge aclk) begin
    hi_cnt <= gate ? hi_cnt + 16'(pwm_out[0]) : 16'h0;
  end
endmodule

// >>> pbc_pkg.sv
// constants and carrier types for the pwm brake and prescale control block
package pbc_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned NUM_OUT       = 4;
  localparam int unsigned CNT_W         = 10;
  // register word indices, byte address is four times the index
  localparam logic [9:0] IDX_BRAKE_PRESCALE = 10'h0d7;
  localparam logic [9:0] IDX_RUN_CONTROL    = 10'h0dc;
  localparam logic [9:0] IDX_BRAKE_CONFIG   = 10'h0df;
  localparam logic [9:0] IDX_IRQ_MASK       = 10'h0e0;
  localparam logic [9:0] IDX_PERIOD         = 10'h0e1;
  localparam logic [9:0] IDX_COMPARE0       = 10'h0e2;
  // brake_config_reg fields
  localparam int unsigned CFG_LEVEL_LSB  = 0;
  localparam int unsigned CFG_EN_BIT     = 4;
  localparam int unsigned CFG_PSEL_BIT   = 5;
  localparam int unsigned CFG_POL_BIT    = 6;
  localparam int unsigned CFG_ISEL_BIT   = 7;
  // run_control_reg fields
  localparam int unsigned RUN_INV_LSB    = 0;
  localparam int unsigned RUN_BIT        = 7;
  // brake_prescale_reg fields
  localparam int unsigned BP_FLAG_BIT    = 0;
  localparam int unsigned BP_PRE_LSB     = 2;
  // reset values
  localparam logic [7:0] RST_BRAKE_CONFIG   = 8'h00;
  localparam logic [7:0] RST_RUN_CONTROL    = 8'h00;
  localparam logic [7:0] RST_BRAKE_PRESCALE = 8'h00;
  // prescaler masks, the divider ticks when the masked count is all ones
  localparam logic [3:0] PRE_MASK_DIV1  = 4'h0;
  localparam logic [3:0] PRE_MASK_DIV2  = 4'h1;
  localparam logic [3:0] PRE_MASK_DIV4  = 4'h3;
  localparam logic [3:0] PRE_MASK_DIV16 = 4'hf;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PBC_SEL_NONE, PBC_SEL_RUN, PBC_SEL_CFG, PBC_SEL_BP, PBC_SEL_MASK, PBC_SEL_PER, PBC_SEL_CMP
  } pbc_sel_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pbc_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pbc_axil_rsp_t;
endpackage

// >>> tb_top.sv
// self-checking testbench for the pwm brake and prescale control block
`define CHK(g, e, m) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("CHECK FAILED %0t %s", $time, m); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pbc_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [1:0] br; logic [31:0] rd;} pbc_row_t;
  localparam logic [11:0] A_BP   = {IDX_BRAKE_PRESCALE, 2'b00};
  localparam logic [11:0] A_RUN  = {IDX_RUN_CONTROL, 2'b00};
  localparam logic [11:0] A_CFG  = {IDX_BRAKE_CONFIG, 2'b00};
  localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_PER  = {IDX_PERIOD, 2'b00};
  localparam logic [11:0] A_CMP  = {IDX_COMPARE0, 2'b00};
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic          pin_level = 1'b0;
  logic          gate = 1'b0;
  pbc_axil_req_t req = '0;
  pbc_axil_rsp_t rsp;
  logic          brake_pin;
  logic [3:0]    pwm_out;
  logic          irq;
  logic [15:0]   hi_cnt;
  int            miscompares = 0;
  int            checked = 0;
  int            cycles = 0;
  // reserved bits read zero and the flag is write-one-to-clear
  pbc_row_t      rows [5] = '{'{A_BP, 32'hff, RESP_OKAY, 32'h0c}, '{A_BP, 32'h04, RESP_OKAY, 32'h04},
                             '{A_BP, 32'h08, RESP_OKAY, 32'h08}, '{A_CFG, 32'ha5, RESP_OKAY, 32'ha5},
                             '{12'h000, 32'h5a, RESP_SLVERR, 32'h0}};
  always #5 aclk = ~aclk;
  pbc_brake_prescale dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
                          .brake_pin(brake_pin), .pwm_out(pwm_out), .irq(irq));
  pbc_brake_src ext (.aclk(aclk), .pin_level(pin_level), .gate(gate), .pwm_out(pwm_out),
                     .brake_pin(brake_pin), .hi_cnt(hi_cnt));
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && rsp.awready === 1'b1) begin
        ad = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!wd && rsp.wready === 1'b1) begin
        wd = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e, m)
  endtask
  // brake reaches the outputs within a few cycles, six leaves margin for the pin synchroniser
  task automatic outc(input logic [3:0] e, input string m);
    cyc(6);
    `CHK(pwm_out, e, m)
  endtask
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    cyc(20);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].d, r);
      `CHK(r, rows[i].br, "write response")
      rd(rows[i].a, d, r);
      `CHK(d, rows[i].rd, "read back")
      `CHK(r, rows[i].br, "read response")
    end
    $display("test registers done");
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rdc(A_BP, {24'h0, RST_BRAKE_PRESCALE}, "prescale reset");
    rdc(A_CFG, {24'h0, RST_BRAKE_CONFIG}, "config reset");
    `CHK(irq, 1'b0, "irq reset")
    $display("test reset done");
    w(A_CFG, 32'h1a);
    outc(4'ha, "software brake");
    w(A_CFG, 32'h8a);
    outc(4'h0, "brake disabled");
    w(A_PER, 32'h3);
    for (int i = 0; i < 4; i++) w(A_CMP + 12'(4 * i), 32'h4);
    w(A_CFG, 32'h95);
    outc(4'h5, "idle brake stopped");
    w(A_RUN, 32'h80);
    outc(4'hf, "idle brake running");
    w(A_RUN, 32'h0);
    outc(4'h5, "idle brake again");
    w(A_CFG, 32'hb5);
    outc(4'hf, "both selects");
    $display("test idle done");
    w(A_CFG, 32'h73);
    w(A_RUN, 32'h80);
    w(A_MASK, 32'h1);
    outc(4'hf, "pin inactive");
    pin_level <= 1'b1;
    outc(4'h3, "pin brake");
    `CHK(irq, 1'b1, "irq raised")
    rdc(A_RUN, 32'h0, "run cleared");
    pin_level <= 1'b0;
    outc(4'hf, "resume");
    rdc(A_BP, 32'h1, "flag sticky");
    w(A_MASK, 32'h0);
    cyc(2);
    `CHK(irq, 1'b0, "irq masked")
    w(A_MASK, 32'h1);
    w(A_BP, 32'h1);
    cyc(2);
    `CHK(irq, 1'b0, "irq cleared")
    rdc(A_BP, 32'h0, "flag cleared");
    w(A_CFG, 32'h33);
    outc(4'h3, "low active");
    pin_level <= 1'b1;
    outc(4'hf, "high inactive");
    $display("test pin done");
    w(A_CFG, 32'h0);
    w(A_CMP, 32'h1);
    for (int p = 0; p < 4; p++) begin
      int dv;
      dv = (p == 3) ? 16 : (1 << p);
      w(A_RUN, 32'h0);
      w(A_BP, 32'(p) << 2);
      w(A_RUN, 32'h80);
      cyc(80);
      gate <= 1'b1;
      cyc(16 * dv);
      gate <= 1'b0;
      #1;
      `CHK(hi_cnt, 16'(4 * dv), "duty")
    end
    $display("test prescale done");
    conclude();
  end
endmodule
